/* File: logic/dmar_top.sv */
// dmar_top.sv: dma address remapping unit with two remap engines
// Notes on behaviour
// [R1] requester id selects root and context entries
// [R2] a valid table translates the address before forwarding
// [R3] no valid table: fault, no access
// [R4] writes into the interrupt message window pass untranslated
// [R5] host physical addresses are 46 bits wide; guest addresses with bits set above bit 45 fault
// [R6] both engines walk four levels, guest address width 48 bits
// [R7] base page is 4K only
// [R8] 2M and 1G pages in default engine only
// [R9] graphics engine serves graphics only, default engine the rest
// [R10] one fault record; may request an interrupt message
// [R11] invalidation waits for pending translated accesses
// [R12] invalidation scopes: all, one domain, one page
// [R13] cache leaf entries, never invalid ones
// [R14] requests inside the bypass range pass unchanged
// [R15] default context for requesters without own context entry
// [R16] boot protection keeps default page table in force
// [R17] each level indexes with next nine address bits, top first
`timescale 1ns/1ps
`include "dmar_map.svh"
module dmar_top (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_REQ_VALID,
  output logic O_REQ_READY,
  input wire logic [15:0] I_REQ_BDF,
  input wire logic [`DMAR_GPA_W-1:0] I_REQ_ADDR,
  input wire logic I_REQ_WRITE,
  output logic O_RSP_VALID,
  output logic [`DMAR_HPA_W-1:0] O_RSP_ADDR,
  output logic O_RSP_FAULT,
  output logic O_RSP_GFX,
  output logic O_MEM_REQ,
  output logic [`DMAR_HPA_W-1:0] O_MEM_ADDR,
  input wire logic I_MEM_ACK,
  input wire logic [63:0] I_MEM_DATA,
  input wire logic I_XLATE_EN,
  input wire logic I_BOOT_PROT,
  input wire logic [`DMAR_PPN_W-1:0] I_ROOT_PPN,
  input wire logic I_DEF_CTX_EN,
  input wire logic [`DMAR_PPN_W-1:0] I_DEF_CTX_PPN,
  input wire logic [`DMAR_DID_W-1:0] I_DEF_CTX_DID,
  input wire logic I_SUPERPAGE_EN,
  input wire logic I_BYPASS_EN,
  input wire logic [`DMAR_GPA_W-1:0] I_BYPASS_LO,
  input wire logic [`DMAR_GPA_W-1:0] I_BYPASS_HI,
  input wire logic I_INV_REQ,
  input wire logic [1:0] I_INV_SCOPE,
  input wire logic [`DMAR_DID_W-1:0] I_INV_DID,
  input wire logic [`DMAR_GPA_W-1:0] I_INV_ADDR,
  output logic O_INV_DONE,
  output logic O_DRAIN,
  input wire logic I_PEND_EMPTY,
  input wire logic I_FAULT_CLR,
  input wire logic I_FAULT_MSI_EN,
  output logic O_FAULT_VALID,
  output logic O_FAULT_OVERFLOW,
  output logic [2:0] O_FAULT_REASON,
  output logic [15:0] O_FAULT_BDF,
  output logic [`DMAR_GPA_W-1:0] O_FAULT_ADDR,
  output logic O_FAULT_MSI
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  dmar_pkg::dmar_state_t st;
  dmar_pkg::dmar_state_t next_st;
  logic [15:0] bdf;
  logic [15:0] next_bdf;
  logic [`DMAR_GPA_W-1:0] gpa;
  logic [`DMAR_GPA_W-1:0] next_gpa;
  logic wr;
  logic next_wr;
  logic gfx;
  logic next_gfx;
  logic [`DMAR_DID_W-1:0] did;
  logic [`DMAR_DID_W-1:0] next_did;
  logic [`DMAR_PPN_W-1:0] tbl;
  logic [`DMAR_PPN_W-1:0] next_tbl;
  logic [1:0] lvl;
  logic [1:0] next_lvl;
  logic next_rsp_valid;
  logic [`DMAR_HPA_W-1:0] next_rsp_addr;
  logic next_rsp_fault;
  logic next_mem_req;
  logic [`DMAR_HPA_W-1:0] next_mem_addr;
  logic next_inv_done;
  logic [1:0] inv_scope;
  logic [1:0] next_inv_scope;
  logic [`DMAR_DID_W-1:0] inv_did;
  logic [`DMAR_DID_W-1:0] next_inv_did;
  logic [`DMAR_VPN_W-1:0] inv_vpn;
  logic [`DMAR_VPN_W-1:0] next_inv_vpn;

  // control pulses and results from the walk
  logic do_pass;
  logic do_xlate;
  logic do_fault;
  logic go_default;
  logic [2:0] flt_reason;
  logic [`DMAR_PPN_W-1:0] x_ppn;
  logic [1:0] x_size;
  logic fill;
  logic inv_pulse;
  logic msi_hit;
  logic bypass_hit;
  logic sp_ok;
  logic ent_ok;
  logic ent_ps;
  logic [`DMAR_VPN_W-1:0] vpn;
  logic [7:0] devfn;

  // cache outputs per engine
  logic dflt_hit;
  logic gfx_hit;
  logic [`DMAR_PPN_W-1:0] dflt_ppn;
  logic [`DMAR_PPN_W-1:0] gfx_ppn;
  logic [1:0] dflt_size;
  logic [1:0] gfx_size;
  logic c_hit;
  logic [`DMAR_PPN_W-1:0] c_ppn;
  logic [1:0] c_size;

  // ---------------------------------------------------------------
  // address helpers
  // ---------------------------------------------------------------
  // host address from page frame, page size and guest offset
  function automatic logic [`DMAR_HPA_W-1:0] join_addr(logic [`DMAR_PPN_W-1:0] ppn,
                                                       logic [1:0] size,
                                                       logic [`DMAR_GPA_W-1:0] ga);
    logic [`DMAR_HPA_W-1:0] base;
    logic [`DMAR_HPA_W-1:0] omask;
    base = {ppn, {`DMAR_PAGE_SHIFT{1'b0}}};
    omask = ~({`DMAR_HPA_W{1'b1}} << (`DMAR_PAGE_SHIFT + `DMAR_LVL_BITS * size));
    return (base & ~omask) | (ga[`DMAR_HPA_W-1:0] & omask);
  endfunction

  // request classification
  assign vpn = gpa[`DMAR_GPA_W-1:`DMAR_PAGE_SHIFT];
  assign devfn = bdf[7:0];
  assign msi_hit = wr && gpa[`DMAR_GPA_W-1:`DMAR_MSI_LSB] == {16'h0, `DMAR_MSI_TAG}; // [R4]
  assign bypass_hit = I_BYPASS_EN && gpa >= I_BYPASS_LO && gpa <= I_BYPASS_HI; // [R14]
  assign sp_ok = !gfx && I_SUPERPAGE_EN; // [R8]
  assign ent_ok = wr ? I_MEM_DATA[`DMAR_ENT_WRITE] : I_MEM_DATA[`DMAR_ENT_READ];
  assign ent_ps = I_MEM_DATA[`DMAR_ENT_PS] && lvl != `DMAR_TOP_LVL && lvl != 2'h0;
  assign c_hit = gfx ? gfx_hit : dflt_hit;
  assign c_ppn = gfx ? gfx_ppn : dflt_ppn;
  assign c_size = gfx ? gfx_size : dflt_size;
  assign O_REQ_READY = st == dmar_pkg::ST_IDLE && !I_INV_REQ;
  assign O_DRAIN = st == dmar_pkg::ST_INV_WAIT; // [R11]

  // ---------------------------------------------------------------
  // walk and invalidation sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_bdf = bdf;
    next_gpa = gpa;
    next_wr = wr;
    next_gfx = gfx;
    next_did = did;
    next_tbl = tbl;
    next_lvl = lvl;
    next_mem_req = O_MEM_REQ;
    next_mem_addr = O_MEM_ADDR;
    next_inv_scope = inv_scope;
    next_inv_did = inv_did;
    next_inv_vpn = inv_vpn;
    next_inv_done = 1'b0;
    inv_pulse = 1'b0;
    do_pass = 1'b0;
    do_xlate = 1'b0;
    do_fault = 1'b0;
    go_default = 1'b0;
    flt_reason = dmar_pkg::FLT_NONE;
    x_ppn = c_ppn;
    x_size = c_size;
    fill = 1'b0;
    case (st)
      dmar_pkg::ST_IDLE: begin
        if (I_INV_REQ) begin
          next_inv_scope = I_INV_SCOPE;
          next_inv_did = I_INV_DID;
          next_inv_vpn = I_INV_ADDR[`DMAR_GPA_W-1:`DMAR_PAGE_SHIFT];
          next_st = dmar_pkg::ST_INV_WAIT;
        end else if (I_REQ_VALID) begin
          next_bdf = I_REQ_BDF;
          next_gpa = I_REQ_ADDR;
          next_wr = I_REQ_WRITE;
          next_gfx = I_REQ_BDF == `DMAR_GFX_BDF; // [R9]
          next_st = dmar_pkg::ST_CLASSIFY;
        end
      end
      dmar_pkg::ST_CLASSIFY: begin
        if (msi_hit || bypass_hit || (!I_XLATE_EN && !I_BOOT_PROT)) begin // [R4] [R14]
          do_pass = 1'b1;
        end else if (gpa[`DMAR_GPA_W-1:`DMAR_HPA_W] != '0) begin // [R5]
          do_fault = 1'b1;
          flt_reason = dmar_pkg::FLT_ADDR_WIDTH;
        end else if (I_BOOT_PROT) begin // [R16]
          go_default = 1'b1;
        end else begin // [R1]
          next_mem_req = 1'b1;
          next_mem_addr = {I_ROOT_PPN, bdf[15:8], `DMAR_ROOT_OFS};
          next_st = dmar_pkg::ST_ROOT;
        end
      end
      dmar_pkg::ST_ROOT: begin
        if (I_MEM_ACK) begin
          if (I_MEM_DATA[`DMAR_ROOT_PRESENT]) begin // [R15]
            next_mem_addr = {I_MEM_DATA[`DMAR_HPA_W-1:`DMAR_PAGE_SHIFT], devfn,
                             `DMAR_CTX_LO_OFS};
            next_st = dmar_pkg::ST_CTX_LO;
          end else begin
            next_mem_req = 1'b0;
            go_default = 1'b1;
          end
        end
      end
      dmar_pkg::ST_CTX_LO: begin
        if (I_MEM_ACK) begin
          next_tbl = I_MEM_DATA[`DMAR_HPA_W-1:`DMAR_PAGE_SHIFT];
          next_mem_addr = {O_MEM_ADDR[`DMAR_HPA_W-1:4], `DMAR_CTX_HI_OFS};
          next_mem_req = 1'b0;
          if (!I_MEM_DATA[`DMAR_CTX_PRESENT]) begin // [R15]
            go_default = 1'b1;
          end else if (I_MEM_DATA[`DMAR_CTX_TT_LSB+:2] == `DMAR_TT_PASS) begin
            do_pass = 1'b1;
          end else if (I_MEM_DATA[`DMAR_CTX_TT_LSB+:2] == `DMAR_TT_XLATE) begin
            next_mem_req = 1'b1;
            next_st = dmar_pkg::ST_CTX_HI;
          end else begin
            do_fault = 1'b1;
            flt_reason = dmar_pkg::FLT_RSVD;
          end
        end
      end
      dmar_pkg::ST_CTX_HI: begin
        if (I_MEM_ACK) begin
          next_mem_req = 1'b0;
          next_did = I_MEM_DATA[`DMAR_CTX_DID_LSB+:`DMAR_DID_W];
          next_st = dmar_pkg::ST_LOOKUP;
        end
      end
      dmar_pkg::ST_LOOKUP: begin
        if (c_hit) begin // [R2]
          do_xlate = 1'b1;
        end else begin
          next_lvl = `DMAR_TOP_LVL; // [R6]
          next_mem_req = 1'b1;
          next_mem_addr = {tbl, `DMAR_LVL_BITS'(gpa >> (`DMAR_PAGE_SHIFT +
                           `DMAR_LVL_BITS * `DMAR_TOP_LVL)), `DMAR_ENT_OFS};
          next_st = dmar_pkg::ST_WALK;
        end
      end
      dmar_pkg::ST_WALK: begin
        if (I_MEM_ACK) begin
          x_ppn = I_MEM_DATA[`DMAR_HPA_W-1:`DMAR_PAGE_SHIFT];
          x_size = lvl;
          next_mem_req = 1'b0;
          if (!I_MEM_DATA[`DMAR_ENT_READ] && !I_MEM_DATA[`DMAR_ENT_WRITE]) begin // [R3]
            do_fault = 1'b1;
            flt_reason = dmar_pkg::FLT_NOT_PRESENT;
          end else if (!ent_ok) begin
            do_fault = 1'b1;
            flt_reason = dmar_pkg::FLT_PERM;
          end else if (ent_ps && !sp_ok) begin // [R8]
            do_fault = 1'b1;
            flt_reason = dmar_pkg::FLT_RSVD;
          end else if (lvl == 2'h0 || ent_ps) begin // [R7] [R8]
            fill = 1'b1; // [R13]
            do_xlate = 1'b1; // [R2]
          end else begin // [R17]
            next_mem_req = 1'b1;
            next_lvl = lvl - 2'h1;
            next_tbl = x_ppn;
            next_mem_addr = {x_ppn, `DMAR_LVL_BITS'(gpa >> (`DMAR_PAGE_SHIFT +
                             `DMAR_LVL_BITS * (lvl - 2'h1))), `DMAR_ENT_OFS};
          end
        end
      end
      dmar_pkg::ST_INV_WAIT: begin
        if (I_PEND_EMPTY) begin // [R11]
          inv_pulse = 1'b1; // [R12]
          next_inv_done = 1'b1;
          next_st = dmar_pkg::ST_IDLE;
        end
      end
      default: next_st = dmar_pkg::ST_IDLE;
    endcase
    // requesters without own context use the default one
    if (go_default) begin
      if (I_DEF_CTX_EN) begin // [R15] [R16]
        next_did = I_DEF_CTX_DID;
        next_tbl = I_DEF_CTX_PPN;
        next_st = dmar_pkg::ST_LOOKUP;
      end else begin // [R3]
        do_fault = 1'b1;
        flt_reason = dmar_pkg::FLT_NO_CTX;
      end
    end
    if (do_pass || do_xlate || do_fault) begin
      next_st = dmar_pkg::ST_IDLE;
    end
  end

  // response word
  always_comb begin
    next_rsp_valid = do_pass || do_xlate || do_fault;
    next_rsp_fault = do_fault; // [R3]
    next_rsp_addr = do_fault ? '0 : O_RSP_ADDR;
    if (do_pass) begin
      next_rsp_addr = gpa[`DMAR_HPA_W-1:0];
    end else if (do_xlate) begin
      next_rsp_addr = join_addr(x_ppn, x_size, gpa); // [R2]
    end
  end

  // registers of the sequencer
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      st <= dmar_pkg::ST_IDLE;
      bdf <= '0;
      gpa <= '0;
      wr <= 1'b0;
      gfx <= 1'b0;
      did <= '0;
      tbl <= '0;
      lvl <= '0;
      O_RSP_VALID <= 1'b0;
      O_RSP_ADDR <= '0;
      O_RSP_FAULT <= 1'b0;
      O_MEM_REQ <= 1'b0;
      O_MEM_ADDR <= '0;
      O_INV_DONE <= 1'b0;
      inv_scope <= '0;
      inv_did <= '0;
      inv_vpn <= '0;
    end else begin
      st <= next_st;
      bdf <= next_bdf;
      gpa <= next_gpa;
      wr <= next_wr;
      gfx <= next_gfx;
      did <= next_did;
      tbl <= next_tbl;
      lvl <= next_lvl;
      O_RSP_VALID <= next_rsp_valid;
      O_RSP_ADDR <= next_rsp_addr;
      O_RSP_FAULT <= next_rsp_fault;
      O_MEM_REQ <= next_mem_req;
      O_MEM_ADDR <= next_mem_addr;
      O_INV_DONE <= next_inv_done;
      inv_scope <= next_inv_scope;
      inv_did <= next_inv_did;
      inv_vpn <= next_inv_vpn;
    end
  end
  assign O_RSP_GFX = gfx;

  // ---------------------------------------------------------------
  // engines: separate caches, invalidation reaches both
  // ---------------------------------------------------------------
  dmar_tcache u_dflt_cache (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_did(did),
    .i_vpn(vpn),
    .o_hit(dflt_hit),
    .o_ppn(dflt_ppn),
    .o_size(dflt_size),
    .i_fill(fill && !gfx), // [R9]
    .i_fill_present(ent_ok),
    .i_fill_ppn(x_ppn),
    .i_fill_size(x_size),
    .i_inv(inv_pulse),
    .i_inv_scope(inv_scope),
    .i_inv_did(inv_did),
    .i_inv_vpn(inv_vpn)
  );

  dmar_tcache u_gfx_cache (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_did(did),
    .i_vpn(vpn),
    .o_hit(gfx_hit),
    .o_ppn(gfx_ppn),
    .o_size(gfx_size),
    .i_fill(fill && gfx), // [R9]
    .i_fill_present(ent_ok),
    .i_fill_ppn(x_ppn),
    .i_fill_size(x_size),
    .i_inv(inv_pulse),
    .i_inv_scope(inv_scope),
    .i_inv_did(inv_did),
    .i_inv_vpn(inv_vpn)
  );

  // ---------------------------------------------------------------
  // fault record
  // ---------------------------------------------------------------
  dmar_fault u_fault (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_fire(do_fault), // [R10]
    .i_reason(flt_reason),
    .i_bdf(bdf),
    .i_addr(gpa),
    .i_clr(I_FAULT_CLR),
    .i_msi_en(I_FAULT_MSI_EN),
    .o_valid(O_FAULT_VALID),
    .o_overflow(O_FAULT_OVERFLOW),
    .o_reason(O_FAULT_REASON),
    .o_bdf(O_FAULT_BDF),
    .o_addr(O_FAULT_ADDR),
    .o_msi(O_FAULT_MSI)
  );
endmodule

/* File: logic/dmar_map.svh */
// dmar_map.svh: constants of the dma address remapping block
`ifndef DMAR_MAP_SVH
`define DMAR_MAP_SVH
`define DMAR_GPA_W 48
`define DMAR_HPA_W 46
`define DMAR_PAGE_SHIFT 12
`define DMAR_LVL_BITS 9
`define DMAR_VPN_W 36
`define DMAR_PPN_W 34
`define DMAR_DID_W 16
`define DMAR_TOP_LVL 2'h3
`define DMAR_ENT_READ 0
`define DMAR_ENT_WRITE 1
`define DMAR_ENT_PS 7
`define DMAR_ROOT_PRESENT 0
`define DMAR_CTX_PRESENT 0
`define DMAR_CTX_TT_LSB 2
`define DMAR_TT_XLATE 2'h0
`define DMAR_TT_PASS 2'h2
`define DMAR_CTX_DID_LSB 8
`define DMAR_ROOT_OFS 4'h0
`define DMAR_CTX_LO_OFS 4'h0
`define DMAR_CTX_HI_OFS 4'h8
`define DMAR_ENT_OFS 3'h0
`define DMAR_MSI_LSB 20
`define DMAR_MSI_TAG 12'hFEE
`define DMAR_GFX_BDF 16'h0010
`define DMAR_TC_DEPTH 4
`define DMAR_TC_PTR_W 2
`endif

/* File: logic/dmar_pkg.sv */
// dmar_pkg.sv: types shared by the dma address remapping block
package dmar_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_CLASSIFY = 4'b0001,
    ST_ROOT = 4'b0010,
    ST_CTX_LO = 4'b0011,
    ST_CTX_HI = 4'b0100,
    ST_LOOKUP = 4'b0101,
    ST_WALK = 4'b0110,
    ST_INV_WAIT = 4'b0111
  } dmar_state_t;
  typedef enum logic [2:0] {
    FLT_NONE = 3'b000,
    FLT_ADDR_WIDTH = 3'b001,
    FLT_NO_CTX = 3'b010,
    FLT_NOT_PRESENT = 3'b011,
    FLT_PERM = 3'b100,
    FLT_RSVD = 3'b101
  } dmar_fault_t;
  typedef enum logic [1:0] {
    SCOPE_ALL = 2'b00,
    SCOPE_DOMAIN = 2'b01,
    SCOPE_PAGE = 2'b10
  } dmar_scope_t;
  typedef enum logic [1:0] {
    SZ_4K = 2'b00,
    SZ_2M = 2'b01,
    SZ_1G = 2'b10
  } dmar_size_t;
endpackage

/* File: logic/dmar_tcache.sv */
// dmar_tcache.sv: translation cache of one remap engine
`timescale 1ns/1ps
`include "dmar_map.svh"
module dmar_tcache (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [`DMAR_DID_W-1:0] i_did,
  input wire logic [`DMAR_VPN_W-1:0] i_vpn,
  output logic o_hit,
  output logic [`DMAR_PPN_W-1:0] o_ppn,
  output logic [1:0] o_size,
  input wire logic i_fill,
  input wire logic i_fill_present,
  input wire logic [`DMAR_PPN_W-1:0] i_fill_ppn,
  input wire logic [1:0] i_fill_size,
  input wire logic i_inv,
  input wire logic [1:0] i_inv_scope,
  input wire logic [`DMAR_DID_W-1:0] i_inv_did,
  input wire logic [`DMAR_VPN_W-1:0] i_inv_vpn
);
  logic [`DMAR_TC_DEPTH-1:0] vld;
  logic [`DMAR_TC_DEPTH-1:0] next_vld;
  logic [`DMAR_DID_W-1:0] tdid [`DMAR_TC_DEPTH];
  logic [`DMAR_DID_W-1:0] next_tdid [`DMAR_TC_DEPTH];
  logic [`DMAR_VPN_W-1:0] tvpn [`DMAR_TC_DEPTH];
  logic [`DMAR_VPN_W-1:0] next_tvpn [`DMAR_TC_DEPTH];
  logic [`DMAR_PPN_W-1:0] tppn [`DMAR_TC_DEPTH];
  logic [`DMAR_PPN_W-1:0] next_tppn [`DMAR_TC_DEPTH];
  logic [1:0] tsize [`DMAR_TC_DEPTH];
  logic [1:0] next_tsize [`DMAR_TC_DEPTH];
  logic [`DMAR_TC_PTR_W-1:0] rr;
  logic [`DMAR_TC_PTR_W-1:0] next_rr;

  // page numbers match above the span that the entry size covers
  function automatic logic vmatch(logic [`DMAR_VPN_W-1:0] a, logic [`DMAR_VPN_W-1:0] b,
                                  logic [1:0] size);
    logic [`DMAR_VPN_W-1:0] mask;
    mask = {`DMAR_VPN_W{1'b1}} << (`DMAR_LVL_BITS * size);
    return ((a ^ b) & mask) == '0;
  endfunction

  // lookup, fill and invalidation
  always_comb begin
    logic [`DMAR_TC_PTR_W-1:0] slot;
    logic found;
    slot = rr;
    found = 1'b0;
    o_hit = 1'b0;
    o_ppn = '0;
    o_size = '0;
    next_vld = vld;
    next_tdid = tdid;
    next_tvpn = tvpn;
    next_tppn = tppn;
    next_tsize = tsize;
    next_rr = rr;
    for (int k = 0; k < `DMAR_TC_DEPTH; k++) begin
      if (vld[k] && tdid[k] == i_did && vmatch(tvpn[k], i_vpn, tsize[k])) begin
        o_hit = 1'b1;
        o_ppn = tppn[k];
        o_size = tsize[k];
      end
      if (!vld[k] && !found) begin
        slot = `DMAR_TC_PTR_W'(k);
        found = 1'b1;
      end
    end
    if (i_fill && i_fill_present) begin // [R13]
      next_vld[slot] = 1'b1;
      next_tdid[slot] = i_did;
      next_tvpn[slot] = i_vpn;
      next_tppn[slot] = i_fill_ppn;
      next_tsize[slot] = i_fill_size;
      if (!found) begin
        next_rr = rr + 1'b1;
      end
    end
    if (i_inv) begin // [R12]
      for (int k = 0; k < `DMAR_TC_DEPTH; k++) begin
        case (i_inv_scope)
          dmar_pkg::SCOPE_ALL: next_vld[k] = 1'b0;
          dmar_pkg::SCOPE_DOMAIN: begin
            if (tdid[k] == i_inv_did) begin
              next_vld[k] = 1'b0;
            end
          end
          dmar_pkg::SCOPE_PAGE: begin
            if (tdid[k] == i_inv_did && vmatch(tvpn[k], i_inv_vpn, tsize[k])) begin
              next_vld[k] = 1'b0;
            end
          end
          default: next_vld[k] = vld[k];
        endcase
      end
    end
  end

  // entry storage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      vld <= '0;
      rr <= '0;
    end else begin
      vld <= next_vld;
      rr <= next_rr;
    end
    tdid <= next_tdid;
    tvpn <= next_tvpn;
    tppn <= next_tppn;
    tsize <= next_tsize;
  end
endmodule

/* File: logic/dmar_fault.sv */
// dmar_fault.sv: single fault record with interrupt message request
`timescale 1ns/1ps
`include "dmar_map.svh"
module dmar_fault (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_fire,
  input wire logic [2:0] i_reason,
  input wire logic [15:0] i_bdf,
  input wire logic [`DMAR_GPA_W-1:0] i_addr,
  input wire logic i_clr,
  input wire logic i_msi_en,
  output logic o_valid,
  output logic o_overflow,
  output logic [2:0] o_reason,
  output logic [15:0] o_bdf,
  output logic [`DMAR_GPA_W-1:0] o_addr,
  output logic o_msi
);
  logic next_valid;
  logic next_overflow;
  logic [2:0] next_reason;
  logic [15:0] next_bdf;
  logic [`DMAR_GPA_W-1:0] next_addr;
  logic next_msi;

  // record the first fault, flag later ones; a new fault beats a clear
  always_comb begin
    next_valid = o_valid;
    next_overflow = o_overflow;
    next_reason = o_reason;
    next_bdf = o_bdf;
    next_addr = o_addr;
    next_msi = 1'b0;
    if (i_clr) begin
      next_valid = 1'b0;
      next_overflow = 1'b0;
    end
    if (i_fire) begin // [R10]
      if (o_valid && !i_clr) begin
        next_overflow = 1'b1;
      end else begin
        next_valid = 1'b1;
        next_reason = i_reason;
        next_bdf = i_bdf;
        next_addr = i_addr;
        next_msi = i_msi_en;
      end
    end
  end

  // record registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_overflow <= 1'b0;
      o_reason <= '0;
      o_bdf <= '0;
      o_addr <= '0;
      o_msi <= 1'b0;
    end else begin
      o_valid <= next_valid;
      o_overflow <= next_overflow;
      o_reason <= next_reason;
      o_bdf <= next_bdf;
      o_addr <= next_addr;
      o_msi <= next_msi;
    end
  end
endmodule

/* File: bench/dmar_top_props.sv */
// dmar_top_props.sv: port assertions of the remap unit
`timescale 1ns/1ps
module dmar_props (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic O_REQ_READY,
  input wire logic O_RSP_VALID,
  input wire logic O_RSP_FAULT,
  input wire logic [45:0] O_RSP_ADDR,
  input wire logic O_MEM_REQ,
  input wire logic I_MEM_ACK,
  input wire logic [45:0] O_MEM_ADDR,
  input wire logic I_INV_REQ,
  input wire logic O_DRAIN,
  input wire logic I_PEND_EMPTY,
  input wire logic O_INV_DONE,
  input wire logic O_FAULT_VALID,
  input wire logic O_FAULT_OVERFLOW,
  input wire logic O_FAULT_MSI
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);
  // response, table read, invalidation and fault record timing
  rsp_pulse_a: assert property (O_RSP_VALID |=> !O_RSP_VALID)
    else $error("response pulse too long");
  fault_zero_a: assert property (O_RSP_VALID && O_RSP_FAULT
    |-> O_RSP_ADDR == 46'h0) else $error("faulted response has address");
  read_hold_a: assert property (O_MEM_REQ && !I_MEM_ACK
    |=> O_MEM_REQ && $stable(O_MEM_ADDR)) else $error("table read dropped");
  drain_wait_a: assert property (O_DRAIN && !I_PEND_EMPTY
    |=> O_DRAIN && !O_INV_DONE) else $error("done before drain");
  inv_done_a: assert property (O_DRAIN && I_PEND_EMPTY
    |=> O_INV_DONE ##1 !O_INV_DONE) else $error("done not one pulse");
  inv_block_a: assert property (I_INV_REQ || O_DRAIN |-> !O_REQ_READY)
    else $error("request taken during invalidation");
  msi_fault_a: assert property (O_FAULT_MSI |-> O_FAULT_VALID ##1 !O_FAULT_MSI)
    else $error("message without record");
  ovf_valid_a: assert property (O_FAULT_OVERFLOW |-> O_FAULT_VALID)
    else $error("overflow without record");
endmodule
bind dmar_top dmar_props u_props (.*);

/* File: bench/dmar_mem_model.sv */
// dmar_mem_model.sv: table memory answering word reads of the unit
`timescale 1ns/1ps
module dmar_mem_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [45:0] i_addr,
  output logic o_ack,
  output logic [63:0] o_data
);
  logic [63:0] m [logic [45:0]];
  logic [45:0] seen [$];
  int lat = 0;
  int cnt = 0;
  initial begin
    o_ack = 1'b0;
    o_data = 64'h0;
  end
  // one ack per word after lat cycles; data inverts when no ack stands
  always @(negedge i_clk) begin
    o_ack <= 1'b0;
    o_data <= ~o_data;
    if (i_req && !o_ack && cnt < lat) begin
      cnt <= cnt + 1;
    end else if (i_req && !o_ack) begin
      o_ack <= 1'b1;
      o_data <= m.exists(i_addr) ? m[i_addr] : 64'h0;
      seen.push_back(i_addr);
      cnt <= 0;
    end
  end
endmodule

/* File: bench/dmar_top_tb.sv */
// dmar_top_tb.sv: self-checking bench of the remap unit
`timescale 1ns/1ps
module dmar_top_tb;
  logic I_CLK, I_SYS_RST, I_REQ_VALID, I_REQ_WRITE, I_MEM_ACK, I_XLATE_EN, I_BOOT_PROT;
  logic I_DEF_CTX_EN, I_SUPERPAGE_EN, I_BYPASS_EN, I_INV_REQ, I_PEND_EMPTY, I_FAULT_CLR;
  logic I_FAULT_MSI_EN, O_REQ_READY, O_RSP_VALID, O_RSP_FAULT, O_RSP_GFX, O_MEM_REQ;
  logic O_INV_DONE, O_DRAIN, O_FAULT_VALID, O_FAULT_OVERFLOW, O_FAULT_MSI;
  logic [1:0] I_INV_SCOPE;
  logic [2:0] O_FAULT_REASON;
  logic [15:0] I_REQ_BDF, I_DEF_CTX_DID, I_INV_DID, O_FAULT_BDF;
  logic [33:0] I_ROOT_PPN, I_DEF_CTX_PPN;
  logic [45:0] O_RSP_ADDR, O_MEM_ADDR;
  logic [47:0] I_REQ_ADDR, I_BYPASS_LO, I_BYPASS_HI, I_INV_ADDR, O_FAULT_ADDR;
  logic [63:0] I_MEM_DATA;
  logic [47:0] ga = 48'h808060_4567;
  logic [45:0] walk [7] = '{46'h1030, 46'h2080, 46'h2088, 46'h3008, 46'h4010,
    46'h5018, 46'h6020};
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  dmar_top DUT (.*);
  dmar_mem_model u_mem (.i_clk(I_CLK), .i_req(O_MEM_REQ), .i_addr(O_MEM_ADDR),
    .o_ack(I_MEM_ACK), .o_data(I_MEM_DATA));
  initial begin
    I_CLK = 1'b0;
    forever #20 I_CLK = ~I_CLK;
  end
  // cuts a hang short
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic check(input string nm, input logic [63:0] seen, want);
    checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_hi(ref logic s);
    int n = 0;
    while (s !== 1'b1 && n < 99) begin
      @(negedge I_CLK);
      n++;
    end
  endtask
  // one request held until taken, then its response judged
  task automatic xfer(input logic [15:0] b, input logic [47:0] a, input logic w,
    input logic [45:0] ea, input logic ef);
    @(negedge I_CLK);
    {I_REQ_BDF, I_REQ_ADDR, I_REQ_WRITE, I_REQ_VALID} = {b, a, w, 1'b1};
    wait_hi(O_REQ_READY);
    @(negedge I_CLK);
    I_REQ_VALID = 1'b0;
    wait_hi(O_RSP_VALID);
    check("addr", O_RSP_ADDR, ea);
    check("fault", O_RSP_FAULT, ef);
  endtask
  // invalidation held back by pending accesses
  task automatic inv(input logic [1:0] sc);
    @(negedge I_CLK);
    {I_INV_SCOPE, I_INV_DID, I_INV_ADDR, I_PEND_EMPTY, I_INV_REQ} = {sc, 16'h5, ga, 2'b01};
    @(negedge I_CLK);
    I_INV_REQ = 1'b0;
    repeat (3) @(negedge I_CLK);
    check("drain", O_DRAIN & ~O_INV_DONE, 1'b1);
    I_PEND_EMPTY = 1'b1;
    wait_hi(O_INV_DONE);
    check("done", O_INV_DONE, 1'b1);
  endtask
  task automatic t_fault();
    xfer(16'h0408, 48'hFEE0_1234, 1'b0, 46'h0, 1'b1);
    @(negedge I_CLK);
    check("reason", {O_FAULT_REASON, O_FAULT_BDF}, {3'h2, 16'h0408});
    xfer(16'h0408, 48'h1000, 1'b0, 46'h0, 1'b1);
    @(negedge I_CLK);
    check("ovf", {O_FAULT_OVERFLOW, O_FAULT_ADDR}, {1'b1, 48'hFEE0_1234});
    I_FAULT_CLR = 1'b1;
    @(negedge I_CLK);
    I_FAULT_CLR = 1'b0;
    @(negedge I_CLK);
    check("clr", O_FAULT_VALID, 1'b0);
  endtask
  task automatic t_pass();
    xfer(16'h0408, 48'hFEE0_1234, 1'b1, 46'hFEE0_1234, 1'b0);
    xfer(16'h0408, 48'h1234_5678, 1'b0, 46'h1234_5678, 1'b0);
    I_BYPASS_EN = 1'b0;
    xfer(16'h0408, 48'h1234_5678, 1'b0, 46'h0, 1'b1);
    I_XLATE_EN = 1'b0;
    xfer(16'h0408, 48'h1234_5678, 1'b0, 46'h1234_5678, 1'b0);
    I_XLATE_EN = 1'b1;
  endtask
  task automatic t_walk();
    u_mem.seen.delete();
    xfer(16'h0308, ga, 1'b0, 46'h7ABC_D567, 1'b0);
    foreach (walk[i]) check("walk", u_mem.seen[i], walk[i]);
    xfer(16'h0308, ga, 1'b1, 46'h7ABC_D567, 1'b0);
    xfer(16'h0308, 48'h4000_0000_0000, 1'b0, 46'h0, 1'b1);
  endtask
  task automatic t_super();
    u_mem.m[46'h5018] = 64'h20_0083;
    inv(2'h0);
    I_SUPERPAGE_EN = 1'b1;
    xfer(16'h0308, ga, 1'b0, 46'h20_4567, 1'b0);
    xfer(16'h0010, ga, 1'b0, 46'h0, 1'b1);
    check("gfx", O_RSP_GFX, 1'b1);
    I_SUPERPAGE_EN = 1'b0;
    inv(2'h1);
    xfer(16'h0308, ga, 1'b0, 46'h0, 1'b1);
    check("gfx", O_RSP_GFX, 1'b0);
  endtask
  task automatic t_boot();
    u_mem.m[46'h5018] = 64'h6003;
    u_mem.lat = 2;
    I_DEF_CTX_EN = 1'b1;
    xfer(16'h0408, ga, 1'b0, 46'h7ABC_D567, 1'b0);
    {I_ROOT_PPN, I_BOOT_PROT} = {34'h3F, 1'b1};
    xfer(16'h0308, ga, 1'b1, 46'h7ABC_D567, 1'b0);
  endtask
  // tables, reset and scenario order
  initial begin
    {I_REQ_VALID, I_REQ_WRITE, I_BOOT_PROT, I_DEF_CTX_EN, I_SUPERPAGE_EN, I_INV_REQ} = '0;
    {I_FAULT_CLR, I_REQ_BDF, I_INV_SCOPE, I_INV_DID, I_INV_ADDR, I_REQ_ADDR} = '0;
    {I_SYS_RST, I_XLATE_EN, I_BYPASS_EN, I_PEND_EMPTY, I_FAULT_MSI_EN} = '1;
    {I_ROOT_PPN, I_DEF_CTX_PPN, I_DEF_CTX_DID} = {34'h1, 34'h3, 16'h9};
    {I_BYPASS_LO, I_BYPASS_HI} = {48'h1000_0000, 48'h1FFF_FFFF};
    u_mem.m[46'h1030] = 64'h2001;
    u_mem.m[46'h1000] = 64'h2001;
    u_mem.m[46'h2080] = 64'h3001;
    u_mem.m[46'h2100] = 64'h3001;
    u_mem.m[46'h2088] = 64'h500;
    u_mem.m[46'h2108] = 64'h500;
    u_mem.m[46'h3008] = 64'h4003;
    u_mem.m[46'h4010] = 64'h5003;
    u_mem.m[46'h5018] = 64'h6003;
    u_mem.m[46'h6020] = 64'h7ABCD003;
    repeat (10) @(negedge I_CLK);
    I_SYS_RST = 1'b0;
    t_fault();
    t_pass();
    t_walk();
    t_super();
    t_boot();
    close_out();
  end
endmodule
